// file: core/cmr_defines.svh
/*
  Offsets, field positions, reset values and scaling figures for the charger
  monitor readback registers. Assumes inclusion by bare name.
*/
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH

// Command codes of the four readback registers
`define CMR_OFS_APPLIED_LIMIT  8'h22
`define CMR_OFS_VOLT_POWER     8'h23
`define CMR_OFS_BATT_CURRENT   8'h24
`define CMR_OFS_INPUT_CURRENT_CMP 8'h25

// Reset values
`define CMR_RST_APPLIED_LIMIT  16'h4100
`define CMR_RST_RESULT         16'h0000
// Code field of the limit reset value, so the code port agrees with the register
`define CMR_RST_LIMIT_CODE     7'h41

// Field positions
`define CMR_LIMIT_MSB          14
`define CMR_LIMIT_LSB          8
`define CMR_RESERVED_TOP       15
`define CMR_HI_MSB             15
`define CMR_HI_LSB             8
`define CMR_CHG_MSB            14
`define CMR_DCHG_MSB           6

// Scaling, reference only: mA or mV per step, or full span, at 10 mohm / range select 0 (RS1 names range select 1)
`define CMR_LIMIT_STEP_MA      50
`define CMR_INPUT_VOLTAGE_STEP_MV     96
`define CMR_INPUT_VOLTAGE_SPAN_MV     24480
`define CMR_SYSTEM_POWER_STEP_RS1_MV  12
`define CMR_SYSTEM_POWER_STEP_RS0_MV  8
`define CMR_CHARGE_CURRENT_STEP_MA    64
`define CMR_DISCHARGE_CURRENT_STEP_MA 256
`define CMR_INPUT_CURRENT_STEP_MA     50

`endif

// file: core/cmr_pkg.sv
/*
  Types for the charger monitor readback registers.
  Assumes cmr_defines.svh supplies the numeric constants.
*/
package cmr_pkg;
  // One register access from the serial command decoder
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } cmr_access_s;

  // New conversion results, with one update strobe per register word
  typedef struct packed {
    logic       limit_vld;
    logic [6:0] limit_code;
    logic       optimizer_done;
    logic       volt_power_vld;
    logic [7:0] input_voltage;
    logic [7:0] system_power;
    logic       ibat_vld;
    logic [6:0] charge_current;
    logic [6:0] discharge_current;
    logic       in_current_cmp_vld;
    logic [7:0] input_current;
    logic [7:0] comparator_input_voltage;
  } cmr_results_s;
endpackage

// file: core/cmr_regs.sv
/*
  Read-only monitor register bank of a charge controller: applied input
  limit, and the three converter result words. Assumes a serial command
  decoder on the same clock presents one-cycle read/write strobes with a
  command code, and that the converter and optimizer deliver results on
  the same clock with one-cycle valid strobes. The host applies the sense
  resistor and converter range scaling itself; reset is asynchronous.
*/
`timescale 1ns/10ps
`include "cmr_defines.svh"

module cmr_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Register access
  input  wire cmr_pkg::cmr_access_s  acc,
  output logic [15:0]                rdata,
  output logic                       rvalid,
  output logic                       invalid_write,
  // Result sources
  input  wire cmr_pkg::cmr_results_s res,
  input  wire logic [6:0]            host_limit_code,
  // Limit currently applied by regulation
  output logic [6:0]                 applied_limit_code
);
  import cmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] applied_limit;
  logic [15:0] bus_voltage_power_result;
  logic [15:0] battery_current_result;
  logic [15:0] input_current_comparator_result;
  logic        optimizer_ran;

  // Scaling (step size per resistor / range select) is applied by the host;
  // the raw codes are stored untouched so one bank serves every setting.
  // Before the optimizer has run the host limit is in force; afterwards only
  // optimizer results move it, so a later host limit change cannot undo it.
  wire [6:0]  next_limit_code = (optimizer_ran || res.optimizer_done)
                                ? (res.limit_vld ? res.limit_code
                                   : applied_limit[`CMR_LIMIT_MSB:`CMR_LIMIT_LSB])
                                : host_limit_code;
  wire [15:0] next_applied    = {1'b0, next_limit_code, 8'h00};
  // Input voltage above, system power below; range select only rescales
  wire [15:0] next_vp         = {res.input_voltage, res.system_power};
  // Discharge code is saturated by the converter; all-ones stays all-ones
  wire [15:0] next_ibat       = {1'b0, res.charge_current,
                                 1'b0, res.discharge_current};
  wire [15:0] next_iic        = {res.input_current, res.comparator_input_voltage};

  wire        sel_limit = acc.cmd == `CMR_OFS_APPLIED_LIMIT;
  wire        sel_vp    = acc.cmd == `CMR_OFS_VOLT_POWER;
  wire        sel_ibat  = acc.cmd == `CMR_OFS_BATT_CURRENT;
  wire        sel_iic   = acc.cmd == `CMR_OFS_INPUT_CURRENT_CMP;
  wire [15:0] rd_mux    = sel_limit ? applied_limit :
                          sel_vp    ? bus_voltage_power_result :
                          sel_ibat  ? battery_current_result :
                          sel_iic   ? input_current_comparator_result : 16'h0000;
  wire        bad_wr    = acc.wr && sel_limit && acc.wdata[`CMR_RESERVED_TOP];

  ////////////////////////////////////////////////////////////////////////////
  // Registers: result words load only on their strobes, the limit every cycle; never from writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      optimizer_ran                   <= 1'b0;
      applied_limit                   <= `CMR_RST_APPLIED_LIMIT;
      bus_voltage_power_result        <= `CMR_RST_RESULT;
      battery_current_result          <= `CMR_RST_RESULT;
      input_current_comparator_result <= `CMR_RST_RESULT;
    end else begin
      optimizer_ran <= optimizer_ran | res.optimizer_done;
      applied_limit <= next_applied;
      if (res.volt_power_vld) begin
        bus_voltage_power_result <= next_vp;
      end
      if (res.ibat_vld) begin
        battery_current_result <= next_ibat;
      end
      if (res.in_current_cmp_vld) begin
        input_current_comparator_result <= next_iic;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and status outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata              <= 16'h0000;
      rvalid             <= 1'b0;
      invalid_write      <= 1'b0;
      applied_limit_code <= `CMR_RST_LIMIT_CODE;
    end else begin
      rvalid             <= acc.rd;
      rdata              <= acc.rd ? rd_mux : rdata;
      invalid_write      <= bad_wr;
      applied_limit_code <= next_limit_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_limit_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    applied_limit[15] == 1'b0 && applied_limit[7:0] == 8'h00)
    else $error("reserved bits of limit register not zero");
  // The release edge still shows the reset value, so it starts no attempt
  a_limit_follows_host: assert property (@(posedge clk) disable iff (!arst_n)
    arst_n && !optimizer_ran && !res.optimizer_done |=>
    applied_limit[14:8] == $past(host_limit_code))
    else $error("limit register does not follow host limit");
  a_optimizer_wins: assert property (@(posedge clk) disable iff (!arst_n)
    optimizer_ran && res.limit_vld |=> applied_limit[14:8] == $past(res.limit_code))
    else $error("optimizer limit not reported");
  a_optimizer_holds: assert property (@(posedge clk) disable iff (!arst_n)
    optimizer_ran && !res.limit_vld |=> $stable(applied_limit))
    else $error("limit changed without optimizer result");
  a_vp_layout: assert property (@(posedge clk) disable iff (!arst_n)
    res.volt_power_vld |=>
    bus_voltage_power_result == {$past(res.input_voltage), $past(res.system_power)})
    else $error("voltage/power word wrong");
  a_ibat_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    !battery_current_result[15] && !battery_current_result[7])
    else $error("battery current reserved bit set");
  a_ibat_layout: assert property (@(posedge clk) disable iff (!arst_n)
    res.ibat_vld |=> battery_current_result[6:0] == $past(res.discharge_current))
    else $error("discharge field wrong");
  a_iic_layout: assert property (@(posedge clk) disable iff (!arst_n)
    res.in_current_cmp_vld |=> input_current_comparator_result ==
    {$past(res.input_current), $past(res.comparator_input_voltage)})
    else $error("input current word wrong");
  a_write_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    acc.wr && !res.in_current_cmp_vld |=> $stable(input_current_comparator_result))
    else $error("write altered a result register");
  a_read_data: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && sel_vp |=> rvalid && rdata == $past(bus_voltage_power_result))
    else $error("read data mismatch");
  a_invalid_flag: assert property (@(posedge clk) disable iff (!arst_n)
    acc.wr && sel_limit && acc.wdata[15] |=> invalid_write)
    else $error("invalid write not flagged");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the limit source
  a_limit_code_port: assert property (@(posedge clk) disable iff (!arst_n)
    applied_limit_code == applied_limit[14:8])
    else $error("limit code port differs from limit register");
  a_limit_same_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    !optimizer_ran && res.optimizer_done && res.limit_vld |=>
    applied_limit[14:8] == $past(res.limit_code))
    else $error("first optimizer limit not reported");
  a_host_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    optimizer_ran && !res.limit_vld |=> $stable(applied_limit_code))
    else $error("host limit leaked past optimizer");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the result words
  a_power_field: assert property (@(posedge clk) disable iff (!arst_n)
    res.volt_power_vld |=> bus_voltage_power_result[7:0] == $past(res.system_power))
    else $error("system power field wrong");
  a_charge_field: assert property (@(posedge clk) disable iff (!arst_n)
    res.ibat_vld |=> battery_current_result[14:8] == $past(res.charge_current))
    else $error("charge current field wrong");
  a_cmp_field: assert property (@(posedge clk) disable iff (!arst_n)
    res.in_current_cmp_vld |=>
    input_current_comparator_result[7:0] == $past(res.comparator_input_voltage))
    else $error("comparator voltage field wrong");
  a_vp_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !res.volt_power_vld |=> $stable(bus_voltage_power_result))
    else $error("voltage/power word moved without strobe");
  a_ibat_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !res.ibat_vld |=> $stable(battery_current_result))
    else $error("battery current word moved without strobe");
  a_iic_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !res.in_current_cmp_vld |=> $stable(input_current_comparator_result))
    else $error("input current word moved without strobe");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the read port
  a_rvalid_set: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_clear: assert property (@(posedge clk) disable iff (!arst_n)
    !acc.rd |=> !rvalid)
    else $error("read answered without request");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !acc.rd |=> $stable(rdata))
    else $error("read data moved without read");
  a_read_limit: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && sel_limit |=> rdata == $past(applied_limit))
    else $error("limit read mismatch");
  a_read_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && sel_limit |=> rdata[15] == 1'b0 && rdata[7:0] == 8'h00)
    else $error("limit read shows reserved bits");
  a_read_ibat: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && sel_ibat |=> rdata == $past(battery_current_result))
    else $error("battery current read mismatch");
  a_read_iic: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && sel_iic |=> rdata == $past(input_current_comparator_result))
    else $error("input current read mismatch");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!arst_n)
    acc.rd && !sel_limit && !sel_vp && !sel_ibat && !sel_iic |=>
    rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_invalid_clear: assert property (@(posedge clk) disable iff (!arst_n)
    !(acc.wr && sel_limit && acc.wdata[15]) |=> !invalid_write)
    else $error("invalid write flagged without cause");
endmodule

// file: tb/cmr_host_model.sv
/*
  Host side of the readback bank: issues one-cycle read and write strobes.
  Assumes the bank answers one clock after the request edge.
*/
`timescale 1ns/10ps
module cmr_host_model (
  // Clock
  input  wire logic            clk,
  // Access toward the bank
  output cmr_pkg::cmr_access_s acc,
  input  wire logic [15:0]     rdata,
  input  wire logic            rvalid,
  input  wire logic            invalid_write
);
  import cmr_pkg::*;
  initial acc = '0;
  // Request held across one edge; answer sampled once that edge has landed
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] d, output logic v, output logic inv);
    @(posedge clk);
    acc <= '{rd: !wr, wr: wr, cmd: cmd, wdata: wd};
    @(posedge clk);
    acc <= '0;
    #1;
    d = rdata;
    v = rvalid;
    inv = invalid_write;
  endtask
  // Host reading of a limit code in mA; code zero reads as one step, and max adds two steps to every code
  function automatic int limit_ma(input logic [6:0] c, input bit r5, input bit mx);
    int step = r5 ? 100 : 50;
    if (c == 7'h00) return mx ? 3 * step : step;
    return c * step + (mx ? 2 * step : 0);
  endfunction
endmodule

// file: tb/tb.sv
/*
  Testbench of the readback bank: reads, refused writes and result updates.
  Assumes the host model in cmr_host_model.sv.
*/
`timescale 1ns/10ps
module tb;
  import cmr_pkg::*;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  cmr_results_s res = '0;
  cmr_results_s r = '0;
  logic [6:0]   host_limit_code = 7'h41;
  cmr_access_s  acc;
  logic [15:0]  rdata;
  logic         rvalid;
  logic         invalid_write;
  logic [6:0]   applied_limit_code;
  logic [15:0]  d;
  logic         v;
  logic         inv;
  logic [15:0]  exp_w [4] = '{16'h4100, 16'ha53c, 16'h7f55, 16'h81ff};
  logic [15:0]  exp_r [4] = '{16'h0500, 16'h0000, 16'h0000, 16'h0000};
  int           n_errors = 0;
  int           checked = 0;
  always #12.5 clk = ~clk;
  cmr_regs dut_u (.clk(clk), .arst_n(arst_n), .acc(acc), .rdata(rdata), .rvalid(rvalid),
    .invalid_write(invalid_write), .res(res), .host_limit_code(host_limit_code),
    .applied_limit_code(applied_limit_code));
  cmr_host_model host_u (.clk(clk), .acc(acc), .rdata(rdata), .rvalid(rvalid),
    .invalid_write(invalid_write));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] cmd);
    host_u.xfer(1'b0, cmd, 16'h0000, d, v, inv);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] wd);
    host_u.xfer(1'b1, cmd, wd, d, v, inv);
  endtask
  task automatic pulse(input cmr_results_s p);
    @(posedge clk);
    res <= p;
    @(posedge clk);
    res <= '0;
  endtask
  task automatic stop_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    r.volt_power_vld = 1'b1;
    {r.input_voltage, r.system_power} = 16'ha53c;
    r.ibat_vld = 1'b1;
    {r.charge_current, r.discharge_current} = 14'h3fd5;
    r.in_current_cmp_vld = 1'b1;
    {r.input_current, r.comparator_input_voltage} = 16'h81ff;
    pulse(r);
    // Every register read, hit with all ones, then read again unchanged
    for (int i = 0; i < 4; i++) begin
      rd(8'h22 + 8'(i));
      check("rvalid", {15'h0, v}, 16'h0001);
      check("word", d, exp_w[i]);
      wr(8'h22 + 8'(i), 16'hffff);
      check("invalid", {15'h0, inv}, {15'h0, i == 0});
      rd(8'h22 + 8'(i));
      check("after write", d, exp_w[i]);
    end
    wr(8'h22, 16'h7fff);
    check("invalid clear", {15'h0, inv}, 16'h0000);
    rd(8'h26);
    check("unmapped", d, 16'h0000);
    $display("test readback done");
    @(posedge clk);
    host_limit_code <= 7'h12;
    rd(8'h22);
    check("host limit", d, 16'h1200);
    r = '0;
    r.optimizer_done = 1'b1;
    r.limit_vld = 1'b1;
    r.limit_code = 7'h33;
    pulse(r);
    host_limit_code <= 7'h05;
    rd(8'h22);
    check("optimizer limit", d, 16'h3300);
    check("applied code", {9'h0, applied_limit_code}, 16'h0033);
    check("nominal 10m", 16'(host_u.limit_ma(d[14:8], 1'b0, 1'b0)), 16'h09f6);
    check("max 5m", 16'(host_u.limit_ma(d[14:8], 1'b1, 1'b1)), 16'h14b4);
    // A later optimizer result alone still moves the limit
    r.optimizer_done = 1'b0;
    r.limit_code = 7'h00;
    pulse(r);
    rd(8'h22);
    check("optimizer zero", d, 16'h0000);
    check("nominal zero", 16'(host_u.limit_ma(d[14:8], 1'b1, 1'b0)), 16'h0064);
    check("max zero", 16'(host_u.limit_ma(d[14:8], 1'b0, 1'b1)), 16'h0096);
    $display("test limit source done");
    // Mid-run reset: results clear and the optimizer choice is forgotten
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    check("reset code", {9'h0, applied_limit_code}, 16'h0041);
    check("reset rvalid", {15'h0, rvalid}, 16'h0000);
    check("reset rdata", rdata, 16'h0000);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'h22 + 8'(i));
      check("after reset", d, exp_r[i]);
    end
    $display("test reset done");
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
